// ---- rtl/amh_pkg.sv ----
// Package with constants and types of the alphanumeric header checker
package amh_pkg;
    // ----------------------------------------------------------------
    // Word layout
    // ----------------------------------------------------------------
    localparam int WORD_W = 21;
    localparam int CHK_W = 10;
    localparam int SIG_W = 7;
    localparam int NUM_W = 6;
    localparam int FRAG_W = 2;
    localparam int CHK_LSB = 0;
    localparam int CONT_BIT = 10;
    localparam int FRAG_LSB = 11;
    localparam int NUM_LSB = 13;
    localparam int RETR_BIT = 19;
    localparam int MAIL_BIT = 20;
    localparam int SPLIT_U_BIT = 19;
    localparam int SPLIT_V_BIT = 20;
    localparam int SIG_LSB = 0;
    localparam int G0_LSB = 0;
    localparam int G1_LSB = 8;
    localparam int G2_LSB = 16;
    localparam int G01_W = 8;
    localparam int G2_W = 5;
    localparam int CHAR_W = 7;
    localparam int CH0_LSB = 0;
    localparam int CH1_LSB = 7;
    localparam int CH2_LSB = 14;
    localparam logic [FRAG_W-1:0] FRAG_INIT = 2'h3;
    localparam logic [FRAG_W-1:0] FRAG_WRAP = 2'h2;
    localparam logic [FRAG_W-1:0] FRAG_FIRST_CONT = 2'h0;
    localparam logic [NUM_W-1:0] NUM_MAX_RST = 6'h3f;

    // Split control decoding
    typedef enum logic [1:0] {
        AMH_SPLIT_NONE = 2'b00,
        AMH_SPLIT_RSVD = 2'b01,
        AMH_SPLIT_DEFAULT = 2'b10,
        AMH_SPLIT_ALT = 2'b11
    } amh_split_t;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_FRAG = 8'h0c;
    localparam logic [7:0] ADDR_MSG = 8'h10;
    localparam logic [7:0] ADDR_SUMS = 8'h14;
    localparam int ADDR_W = 8;
    localparam int EV_W = 6;
    localparam int EV_FRAG_DONE = 0;
    localparam int EV_CHK_BAD = 1;
    localparam int EV_MSG_DONE = 2;
    localparam int EV_SIG_BAD = 3;
    localparam int EV_MISSED = 4;
    localparam int EV_SEQ_BAD = 5;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ---- rtl/amh_checker.sv ----
// Header checker for received alphanumeric paging message fragments
`timescale 1ns/1ps
module amh_checker (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Decoded word stream
    input wire logic word_valid_i,
    input wire logic [amh_pkg::WORD_W-1:0] word_i,
    input wire logic frag_start_i,
    input wire logic frag_end_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [amh_pkg::ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Results
    output logic frag_done_o,
    output logic chk_bad_o,
    output logic sig_bad_o,
    output logic missed_o,
    output logic mail_drop_o,
    output logic [1:0] split_mode_o,
    output logic irq_o
);
    import amh_pkg::*;

    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MAX_LSB = 8;

    // ----------------------------------------------------------------
    // Word field extraction
    // ----------------------------------------------------------------
    // Word position and running sums
    logic second_word_q;
    logic init_frag_q;
    logic [CHK_W-1:0] sum_q;
    logic [SIG_W-1:0] sig_sum_q;
    logic [CHK_W-1:0] rx_chk_q;
    logic [SIG_W-1:0] rx_sig_q;

    // Captured header fields
    logic cont_q;
    logic [FRAG_W-1:0] frag_num_q;
    logic [NUM_W-1:0] msg_num_q;
    logic retr_q;
    logic mail_q;

    // Continuation and numbering history
    logic in_msg_q;
    logic [FRAG_W-1:0] exp_frag_q;
    logic [NUM_W-1:0] last_num_q;
    logic have_num_q;

    // Host settings and status
    logic [NUM_W-1:0] num_max_q;
    logic enable_q;
    logic [1:0] split_q;
    logic [EV_W-1:0] stat_q;
    logic [EV_W-1:0] mask_q;

    // Result pulses
    logic frag_done_q;
    logic chk_bad_q;
    logic sig_bad_q;
    logic missed_q;

    // Qualified word and header fields
    wire word_ok = ce_i && enable_q && word_valid_i;
    wire is_hdr = word_ok && frag_start_i;
    wire [FRAG_W-1:0] hdr_frag = word_i[FRAG_LSB +: FRAG_W];
    wire [NUM_W-1:0] hdr_num = word_i[NUM_LSB +: NUM_W];
    wire hdr_cont = word_i[CONT_BIT];
    // A start fragment is the only one that carries number 3
    wire hdr_init = hdr_frag == FRAG_INIT;

    // ----------------------------------------------------------------
    // Check and signature arithmetic
    // ----------------------------------------------------------------
    // Group sum of the word, sign free ten-bit accumulation
    wire [CHK_W-1:0] grp_sum =
        CHK_W'(word_i[G0_LSB +: G01_W]) +
        CHK_W'(word_i[G1_LSB +: G01_W]) +
        CHK_W'(word_i[G2_LSB +: G2_W]);
    // Accumulator restarts on every header word
    wire [CHK_W-1:0] sum_base = is_hdr ? '0 : sum_q;
    wire [CHK_W-1:0] sum_next = sum_base + grp_sum;
    wire [CHK_W-1:0] chk_calc = ~sum_next;

    // Character sum; the signature field itself is skipped
    wire [SIG_W-1:0] ch0 = word_i[CH0_LSB +: CHAR_W];
    wire [SIG_W-1:0] ch1 = word_i[CH1_LSB +: CHAR_W];
    wire [SIG_W-1:0] ch2 = word_i[CH2_LSB +: CHAR_W];
    wire sig_word = second_word_q && init_frag_q;
    wire [SIG_W-1:0] char_sum = sig_word ? ch1 + ch2 : ch0 + ch1 + ch2;
    // A start header opens a new signature
    wire msg_fresh = is_hdr && hdr_init;
    wire [SIG_W-1:0] sig_base = msg_fresh ? '0 : sig_sum_q;
    wire [SIG_W-1:0] sig_next =
        is_hdr ? sig_base : sig_base + char_sum;
    wire [SIG_W-1:0] sig_calc = ~sig_next;
    wire [SIG_W-1:0] rx_sig_now = sig_word ? ch0 : rx_sig_q;

    // ----------------------------------------------------------------
    // Sequence and numbering checks
    // ----------------------------------------------------------------
    // Fragment number expected next: 0, 1, 2, 0 ... never 3
    wire [FRAG_W-1:0] frag_succ =
        (frag_num_q == FRAG_WRAP || frag_num_q == FRAG_INIT) ?
        FRAG_FIRST_CONT : frag_num_q + 2'h1;

    // Continuation header must match message and fragment number
    wire seq_bad = is_hdr && !hdr_init &&
        (!in_msg_q || hdr_frag != exp_frag_q ||
         hdr_num != msg_num_q);

    // Next consecutive number for missed detection, with roll-over
    wire [NUM_W-1:0] num_succ =
        (last_num_q >= num_max_q) ? '0 : last_num_q + 6'h01;
    wire num_gap = is_hdr && hdr_init &&
        word_i[RETR_BIT] && have_num_q && hdr_num != num_succ;

    // End of fragment and end of message comparisons
    wire frag_last = word_ok && frag_end_i;
    wire chk_mis = frag_last && chk_calc != (is_hdr ?
        word_i[CHK_LSB +: CHK_W] : rx_chk_q);
    wire msg_last = frag_last && !(is_hdr ? hdr_cont : cont_q);
    wire sig_mis = msg_last && sig_calc != rx_sig_now;

    // ----------------------------------------------------------------
    // Fragment tracking
    // ----------------------------------------------------------------
    // Word position and per-fragment header capture
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            second_word_q <= 1'b0;
            init_frag_q <= 1'b0;
            sum_q <= '0;
            rx_chk_q <= '0;
            cont_q <= 1'b0;
            frag_num_q <= '0;
        end else if (word_ok) begin
            second_word_q <= is_hdr;
            sum_q <= sum_next;
            if (is_hdr) begin
                init_frag_q <= hdr_init;
                rx_chk_q <= word_i[CHK_LSB +: CHK_W];
                cont_q <= hdr_cont;
                frag_num_q <= hdr_frag;
            end
        end
    end

    // Message level state: signature, number, mail drop, split mode
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sig_sum_q <= '0;
            rx_sig_q <= '0;
            msg_num_q <= '0;
            retr_q <= 1'b0;
            mail_q <= 1'b0;
            split_q <= AMH_SPLIT_NONE;
        end else if (word_ok) begin
            sig_sum_q <= sig_next;
            if (sig_word) begin
                rx_sig_q <= ch0;
            end
            if (msg_fresh) begin
                msg_num_q <= hdr_num;
                retr_q <= word_i[RETR_BIT];
                mail_q <= word_i[MAIL_BIT];
                split_q <= AMH_SPLIT_DEFAULT;
            end else if (is_hdr) begin
                split_q <= {word_i[SPLIT_U_BIT],
                            word_i[SPLIT_V_BIT]};
            end
        end
    end

    // Continuation expectation and numbering history
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            in_msg_q <= 1'b0;
            exp_frag_q <= FRAG_FIRST_CONT;
            last_num_q <= '0;
            have_num_q <= 1'b0;
        end else if (word_ok) begin
            if (frag_last) begin
                in_msg_q <= !msg_last;
                exp_frag_q <= frag_succ;
            end
            if (is_hdr && hdr_init && word_i[RETR_BIT]) begin
                last_num_q <= hdr_num;
                have_num_q <= 1'b1;
            end
        end
    end

    // Result pulses toward the host
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            frag_done_q <= 1'b0;
            chk_bad_q <= 1'b0;
            sig_bad_q <= 1'b0;
            missed_q <= 1'b0;
        end else if (ce_i) begin
            frag_done_q <= frag_last;
            chk_bad_q <= chk_mis;
            sig_bad_q <= sig_mis;
            missed_q <= num_gap;
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------------------------------
    // Write address held into its data phase
    logic wr_pend_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [31:0] rdata_q;

    // Transfer qualifiers and write strobes
    wire ahb_go = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
    wire ahb_rd = ahb_go && !hwrite_i;
    wire wr_ctrl = wr_pend_q && wr_addr_q == ADDR_CTRL;
    wire wr_stat = wr_pend_q && wr_addr_q == ADDR_STAT;
    wire wr_mask = wr_pend_q && wr_addr_q == ADDR_MASK;

    // ----------------------------------------------------------------
    // Event status
    // ----------------------------------------------------------------
    // Events in status bit order
    wire [EV_W-1:0] ev_set;
    assign ev_set[EV_FRAG_DONE] = frag_last;
    assign ev_set[EV_CHK_BAD] = chk_mis;
    assign ev_set[EV_MSG_DONE] = msg_last;
    assign ev_set[EV_SIG_BAD] = sig_mis;
    assign ev_set[EV_MISSED] = num_gap;
    assign ev_set[EV_SEQ_BAD] = seq_bad;
    // Write-one-to-clear from the status write
    wire [EV_W-1:0] ev_clr = wr_stat ? hwdata_i[EV_W-1:0] : '0;

    // Address decode of the address phase
    wire sel_ctrl = haddr_i == ADDR_CTRL;
    wire sel_stat = haddr_i == ADDR_STAT;
    wire sel_mask = haddr_i == ADDR_MASK;
    wire sel_frag = haddr_i == ADDR_FRAG;
    wire sel_msg = haddr_i == ADDR_MSG;
    wire sel_sums = haddr_i == ADDR_SUMS;

    // Register views as read by the host; bit 10 of the fragment view is 0
    wire [31:0] view_ctrl = {18'h0, num_max_q, 7'h0, enable_q};
    wire [31:0] view_stat = {26'h0, stat_q};
    wire [31:0] view_mask = {26'h0, mask_q};
    wire [31:0] view_frag = {15'h0, split_q, in_msg_q, cont_q,
        frag_num_q, 1'b0, rx_chk_q};
    wire [31:0] view_msg = {14'h0, have_num_q, last_num_q, mail_q,
        retr_q, init_frag_q, msg_num_q, exp_frag_q};
    wire [31:0] view_sums = {8'h0, sig_sum_q, rx_sig_q, sum_q};

    // Read mux; unmapped offsets read as zero
    wire [31:0] rd_mux =
        ({32{sel_ctrl}} & view_ctrl) |
        ({32{sel_stat}} & view_stat) |
        ({32{sel_mask}} & view_mask) |
        ({32{sel_frag}} & view_frag) |
        ({32{sel_msg}} & view_msg) |
        ({32{sel_sums}} & view_sums);

    // Bus phase capture and register writes
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            rdata_q <= '0;
            enable_q <= 1'b1;
            num_max_q <= NUM_MAX_RST;
            mask_q <= '0;
        end else if (ce_i) begin
            wr_pend_q <= ahb_go && hwrite_i;
            wr_addr_q <= haddr_i;
            if (ahb_rd) begin
                rdata_q <= rd_mux;
            end
            if (wr_ctrl) begin
                enable_q <= hwdata_i[CTRL_EN_BIT];
                num_max_q <= hwdata_i[CTRL_MAX_LSB +: NUM_W];
            end
            if (wr_mask) begin
                mask_q <= hwdata_i[EV_W-1:0];
            end
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            stat_q <= '0;
        end else if (ce_i) begin
            stat_q <= (stat_q & ~ev_clr) | ev_set;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Bus answer is always ready and OKAY; results come from flops
    assign hrdata_o = rdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign frag_done_o = frag_done_q;
    assign chk_bad_o = chk_bad_q;
    assign sig_bad_o = sig_bad_q;
    assign missed_o = missed_q;
    assign mail_drop_o = mail_q;
    assign split_mode_o = split_q;
    assign irq_o = |(stat_q & mask_q);
endmodule

// ---- tb/amh_rules_checker.sv ----
// Port-level assertions for the header checker
`timescale 1ns/1ps
module amh_rules_chk (
    // Clock, reset and word stream
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic word_valid_i,
    input wire logic [amh_pkg::WORD_W-1:0] word_i,
    input wire logic frag_start_i,
    input wire logic frag_end_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [amh_pkg::ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Results
    input wire logic frag_done_o,
    input wire logic chk_bad_o,
    input wire logic sig_bad_o,
    input wire logic missed_o,
    input wire logic mail_drop_o,
    input wire logic [1:0] split_mode_o,
    input wire logic irq_o
);
    import amh_pkg::*;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    // Stream qualifiers and the check value of a one-word fragment
    wire take = ce_i & word_valid_i;
    wire hdr = take & frag_start_i;
    wire ini = word_i[FRAG_LSB+:FRAG_W] == FRAG_INIT;
    wire [9:0] sum1 = 10'(word_i[7:0]) + 10'(word_i[15:8])
        + 10'(word_i[20:16]);
    wire bad1 = 10'(~sum1) != word_i[9:0];
    sequence s_one;
        hdr & frag_end_i;
    endsequence
    sequence s_cont;
        hdr & !ini & !frag_end_i ##1 take & frag_end_i;
    endsequence
    a_done_end: assert property (take & frag_end_i |=> frag_done_o)
        else $error("fragment done missing");
    a_done_cause: assert property (frag_done_o |->
        $past(take & frag_end_i))
        else $error("fragment done without end word");
    a_chk_value: assert property (s_one |=> chk_bad_o == $past(bad1))
        else $error("check flag wrong");
    a_chk_paired: assert property (chk_bad_o |-> frag_done_o)
        else $error("check flag without done");
    a_sig_paired: assert property (sig_bad_o |-> frag_done_o)
        else $error("signature flag without done");
    a_missed_cause: assert property (missed_o |->
        $past(hdr & ini & word_i[RETR_BIT])) else $error("missed unexpected");
    a_init_mode: assert property (s_one ##0 ini |=> split_mode_o == 2'b10
        && mail_drop_o == $past(word_i[MAIL_BIT])) else $error("init mode");
    a_cont_mode: assert property (s_cont |=> split_mode_o ==
        $past({word_i[SPLIT_U_BIT], word_i[SPLIT_V_BIT]}, 2))
        else $error("split mode wrong");
endmodule
bind amh_checker amh_rules_chk i_amh_rules_chk (.clk_i(clk_i),
    .srst_i(srst_i), .ce_i(ce_i), .word_valid_i(word_valid_i),
    .word_i(word_i), .frag_start_i(frag_start_i), .frag_end_i(frag_end_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .frag_done_o(frag_done_o), .chk_bad_o(chk_bad_o),
    .sig_bad_o(sig_bad_o), .missed_o(missed_o), .mail_drop_o(mail_drop_o),
    .split_mode_o(split_mode_o), .irq_o(irq_o));

// ---- tb/amh_tx_model.sv ----
// Sender model: demodulated words of one fragment at a time
`timescale 1ns/1ps
module amh_tx_model (
    // Clock
    input wire logic clk_i,
    // Word stream
    output logic word_valid_o,
    output logic [20:0] word_o,
    output logic frag_start_o,
    output logic frag_end_o
);
    initial begin
        word_valid_o = 1'b0;
        word_o = 21'h0;
        frag_start_o = 1'b0;
        frag_end_o = 1'b0;
    end
    // Group sum of one word
    function automatic logic [9:0] grp(input logic [20:0] w);
        return 10'(w[7:0]) + 10'(w[15:8]) + 10'(w[20:16]);
    endfunction
    // Closes the check field, optionally spoils it, sends the words
    task automatic send(input logic [20:0] q[$], input logic bad);
        logic [9:0] s;
        logic [20:0] w;
        int n;
        s = 10'h0;
        n = (q.size() > 84) ? 84 : q.size();
        for (int i = 1; i < n; i++) s += grp(q[i]);
        for (int k = 0; k < 1024; k++) begin
            w = {q[0][20:10], 10'(k)};
            if (10'(~(s + grp(w))) == w[9:0]) break;
        end
        q[0] = w ^ 21'(bad);
        for (int i = 0; i < n; i++) begin
            word_valid_o <= 1'b1;
            word_o <= q[i];
            frag_start_o <= (i == 0);
            frag_end_o <= (i == n - 1);
            @(posedge clk_i);
        end
        word_valid_o <= 1'b0;
        word_o <= ~q[n-1]; // Released: never shows the last word
        frag_start_o <= 1'b0;
        frag_end_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule

// ---- tb/amh_checker_tb.sv ----
// Self-checking bench of the header checker
`timescale 1ns/1ps
module amh_checker_tb;
    import amh_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [7:0] haddr_i = 8'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o, r;
    logic hreadyout_o, hresp_o, word_valid_i, frag_start_i, frag_end_i;
    logic [20:0] word_i;
    logic frag_done_o, chk_bad_o, sig_bad_o, missed_o, mail_drop_o, irq_o;
    logic [1:0] split_mode_o;
    int n_fail = 0;
    int checks = 0;
    int nd = 0, nk = 0, ns = 0, nm = 0;
    always #5 clk_i = ~clk_i;
    amh_checker i_amh_checker (.clk_i, .srst_i, .ce_i, .word_valid_i,
        .word_i, .frag_start_i, .frag_end_i, .hsel_i(1'b1), .haddr_i,
        .htrans_i, .hwrite_i, .hsize_i(HSIZE_WORD), .hwdata_i,
        .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
        .frag_done_o, .chk_bad_o, .sig_bad_o, .missed_o, .mail_drop_o,
        .split_mode_o, .irq_o);
    amh_tx_model i_amh_tx_model (.clk_i, .word_valid_o(word_valid_i),
        .word_o(word_i), .frag_start_o(frag_start_i), .frag_end_o(frag_end_i));
    // Pulse counters
    always @(posedge clk_i) begin
        nd <= nd + int'(frag_done_o === 1'b1);
        nk <= nk + int'(chk_bad_o === 1'b1);
        ns <= ns + int'(sig_bad_o === 1'b1);
        nm <= nm + int'(missed_o === 1'b1);
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One AHB-Lite single transfer
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        htrans_i <= HTRANS_NONSEQ;
        haddr_i <= a;
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
    endtask
    // Header word: {mail or V, retrieval or U} on top
    function automatic logic [20:0] hd(logic c, logic [1:0] f, logic [5:0] n,
        logic [1:0] t);
        return {t, n, f, c, 10'h0};
    endfunction
    task automatic t_regs;
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", r, 32'h3f01);
        chk("resp", hresp_o, 32'h0);
        bus(1'b0, ADDR_MASK, 32'h0);
        chk("mask", r, 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", r, 32'h0);
    endtask
    task automatic t_msg;
        logic [6:0] c [5];
        logic [6:0] s;
        for (int i = 0; i < 5; i++) begin
            s = 7'h0;
            foreach (c[j]) begin
                c[j] = 7'h41 + 7'(i + j);
                s += c[j];
            end
            s = ~s ^ 7'(i == 4);
            i_amh_tx_model.send({hd(1'b1, FRAG_INIT, 6'(i), {i[0], 1'b1}),
                {c[1], c[0], s}}, 1'b0);
            idle(3);
            chk("mode", split_mode_o, AMH_SPLIT_DEFAULT);
            chk("mail", mail_drop_o, i[0]);
            i_amh_tx_model.send({hd(1'b0, FRAG_FIRST_CONT, 6'(i),
                {i[0], i[1]}), {c[4], c[3], c[2]}}, 1'b0);
            idle(3);
            chk("mode", split_mode_o, 32'(i[1:0]));
        end
        chk("sig", ns, 1);
        chk("k", nk, 0);
        chk("done", nd, 10);
        chk("miss", nm, 0);
    endtask
    // Padded message, then a word while the clock enable is low
    task automatic t_pad;
        logic [6:0] s;
        int d0;
        s = ~(7'h41 + 7'h03);
        i_amh_tx_model.send({hd(1'b0, FRAG_INIT, 6'h0, 2'h0),
            {7'h03, 7'h41, s}}, 1'b0);
        idle(3);
        chk("pad sig", ns, 1);
        chk("pad k", nk, 0);
        d0 = nd;
        ce_i <= 1'b0;
        i_amh_tx_model.send({hd(1'b0, FRAG_INIT, 6'h1, 2'h0)}, 1'b1);
        ce_i <= 1'b1;
        idle(3);
        chk("frozen", nd - d0, 0);
    endtask
    task automatic t_num;
        i_amh_tx_model.send({hd(1'b0, FRAG_INIT, 6'h6, 2'h1)}, 1'b1);
        idle(3);
        chk("k", nk, 1);
        chk("miss", nm, 1);
        i_amh_tx_model.send({hd(1'b0, FRAG_INIT, 6'h9, 2'h0)}, 1'b0);
        idle(3);
        chk("k", nk, 1);
        chk("miss", nm, 1);
    endtask
    task automatic t_irq;
        bus(1'b1, ADDR_STAT, 32'h3f);
        bus(1'b0, ADDR_STAT, 32'h0);
        chk("stat", r, 32'h0);
        i_amh_tx_model.send({hd(1'b0, FRAG_INIT, 6'ha, 2'h0)}, 1'b1);
        idle(3);
        bus(1'b0, ADDR_STAT, 32'h0);
        chk("stat", r & 32'h3, 32'h3);
        chk("irq", irq_o, 1'b0);
        bus(1'b1, ADDR_MASK, 32'h2);
        idle(1);
        chk("irq", irq_o, 1'b1);
        bus(1'b1, ADDR_STAT, 32'h2);
        idle(1);
        chk("irq", irq_o, 1'b0);
        i_amh_tx_model.send({hd(1'b0, FRAG_FIRST_CONT, 6'ha, 2'h0)}, 1'b0);
        idle(3);
        bus(1'b0, ADDR_STAT, 32'h0);
        chk("seq", r & 32'h22, 32'h20);
        chk("irq", irq_o, 1'b0);
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        t_regs;
        t_msg;
        t_pad;
        t_num;
        t_irq;
        wrap_up;
    end
    // Watchdog
    initial begin
        #50us;
        n_fail++;
        wrap_up;
    end
endmodule
